// ---- hdl/disk_port_dev.sv ----
// Controller end of the host port: decode, status, handshake, command intake
`timescale 1ns/10ps
module disk_port_dev (
   input wire logic clock,
   input wire logic rst,
   disk_bus_if.dev bus,
   input wire logic [3:0] cfg_jumpers,
   input wire logic proc_ready,
   input wire logic data_start,
   input wire logic data_to_host,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic done,
   input wire logic [7:0] done_status,
   output logic master_reset_pulse,
   output logic cmd_valid,
   output logic [47:0] cmd_block,
   output logic cmd_legal,
   output logic cmd_diag,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic tx_ready
);
   disk_port_pkg::dev_state_e state_ff;
   logic req_ff;
   logic cd_ff;
   logic io_ff;
   logic irq_pend_ff;
   logic [2:0] cnt_ff;
   logic [7:0] hold_ff;
   logic [1:0] mask_ff;
   logic [47:0] blk_ff;
   logic data_acc;
   logic io_sel;
   logic wr_data;
   logic rd_data;
   logic wr_reset;
   logic rd_stat;
   logic wr_sel;
   logic rd_cfg;
   logic wr_mask;
   logic rom_hit;
   logic busy;
   logic dma_rdy;
   logic take_byte;
   logic [7:0] status_byte;

   // Port decode; DMA acknowledge always means the data port
   assign data_acc = bus.dack | (bus.addr == disk_port_pkg::PORT_DATA);
   assign io_sel = !bus.dack;
   assign wr_data = bus.iow & data_acc;
   assign rd_data = bus.ior & data_acc;
   assign wr_reset = bus.iow & io_sel & (bus.addr == disk_port_pkg::PORT_STAT);
   assign rd_stat = bus.ior & io_sel & (bus.addr == disk_port_pkg::PORT_STAT);
   assign wr_sel = bus.iow & io_sel & (bus.addr == disk_port_pkg::PORT_CFG);
   assign rd_cfg = bus.ior & io_sel & (bus.addr == disk_port_pkg::PORT_CFG);
   assign wr_mask = bus.iow & io_sel & (bus.addr == disk_port_pkg::PORT_MASK);
   assign rom_hit = bus.memr
                    & (bus.addr[19:disk_port_pkg::ROM_AW] == disk_port_pkg::ROM_BASE[19:disk_port_pkg::ROM_AW]);

   // Status flags derived from the sequencer
   assign busy = (state_ff != disk_port_pkg::D_IDLE) && (state_ff != disk_port_pkg::D_NOT_READY);
   assign dma_rdy = (state_ff == disk_port_pkg::D_DATA) & req_ff;
   assign take_byte = tx_valid & tx_ready;

   // Status byte; top two bits read as zero
   always_comb begin
      status_byte = 8'h00;
      status_byte[disk_port_pkg::ST_IRQ] = irq_pend_ff;
      status_byte[disk_port_pkg::ST_DRQ] = dma_rdy;
      status_byte[disk_port_pkg::ST_BSY] = busy;
      status_byte[disk_port_pkg::ST_CD] = cd_ff;
      status_byte[disk_port_pkg::ST_IO] = io_ff;
      status_byte[disk_port_pkg::ST_REQ] = req_ff;
   end

   // Main handshake sequencer; master reset acts like power-up but leaves hold_ff unchanged
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= disk_port_pkg::D_NOT_READY;
         req_ff <= 1'b0;
         cd_ff <= 1'b0;
         io_ff <= 1'b0;
         irq_pend_ff <= 1'b0;
         cnt_ff <= 3'h0;
         hold_ff <= 8'h00;
      end else if (wr_reset) begin
         state_ff <= disk_port_pkg::D_NOT_READY;
         req_ff <= 1'b0;
         cd_ff <= 1'b0;
         io_ff <= 1'b0;
         irq_pend_ff <= 1'b0;
         cnt_ff <= 3'h0;
      end else begin
         unique case (state_ff)
            disk_port_pkg::D_NOT_READY: begin
               if (proc_ready) begin
                  state_ff <= disk_port_pkg::D_IDLE;
               end
            end
            disk_port_pkg::D_IDLE: begin
               cd_ff <= 1'b0;
               io_ff <= 1'b0;
               if (wr_sel) begin
                  state_ff <= disk_port_pkg::D_CMD;
                  req_ff <= 1'b1;
                  cnt_ff <= 3'h0;
               end
            end
            disk_port_pkg::D_CMD: begin
               if (req_ff && wr_data) begin
                  req_ff <= 1'b0;
                  cnt_ff <= cnt_ff + 3'h1;
                  if (cnt_ff == disk_port_pkg::CMD_LEN - 3'h1) begin
                     state_ff <= disk_port_pkg::D_EXEC;
                  end
               end else if (!req_ff) begin
                  req_ff <= 1'b1;
               end
            end
            disk_port_pkg::D_EXEC: begin
               if (done) begin
                  state_ff <= disk_port_pkg::D_STAT;
                  hold_ff <= done_status;
                  cd_ff <= 1'b0;
                  io_ff <= 1'b1;
                  req_ff <= 1'b1;
                  irq_pend_ff <= 1'b1;
               end else if (data_start) begin
                  state_ff <= disk_port_pkg::D_DATA;
                  cd_ff <= 1'b1;
                  io_ff <= data_to_host;
                  req_ff <= !data_to_host;
               end
            end
            disk_port_pkg::D_DATA: begin
               if (done) begin
                  state_ff <= disk_port_pkg::D_STAT;
                  hold_ff <= done_status;
                  cd_ff <= 1'b0;
                  io_ff <= 1'b1;
                  req_ff <= 1'b1;
                  irq_pend_ff <= 1'b1;
               end else if (io_ff) begin
                  if (req_ff && rd_data) begin
                     req_ff <= 1'b0;
                  end else if (take_byte) begin
                     hold_ff <= tx_data;
                     req_ff <= 1'b1;
                  end
               end else if (req_ff && wr_data) begin
                  req_ff <= 1'b0;
               end else if (!req_ff) begin
                  req_ff <= 1'b1;
               end
            end
            disk_port_pkg::D_STAT: begin
               if (req_ff && rd_data) begin
                  req_ff <= 1'b0;
                  irq_pend_ff <= 1'b0;
                  state_ff <= disk_port_pkg::D_IDLE;
               end
            end
            default: begin
               state_ff <= disk_port_pkg::D_NOT_READY;
            end
         endcase
      end
   end

   // Free slot for the processor while sending to the host
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_ready <= 1'b0;
      end else if (wr_reset) begin
         tx_ready <= 1'b0;
      end else if (state_ff == disk_port_pkg::D_EXEC && !done && data_start && data_to_host) begin
         tx_ready <= 1'b1;
      end else if (state_ff == disk_port_pkg::D_DATA && done) begin
         tx_ready <= 1'b0;
      end else if (take_byte) begin
         tx_ready <= 1'b0;
      end else if (state_ff == disk_port_pkg::D_DATA && io_ff && req_ff && rd_data) begin
         tx_ready <= 1'b1;
      end
   end

   // Command block capture, byte 0 lands in the top byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         blk_ff <= 48'h000000000000;
      end else if (state_ff == disk_port_pkg::D_CMD && req_ff && wr_data) begin
         blk_ff <= {blk_ff[39:0], bus.bus_d};
      end
   end

   // One-cycle notifications to the controller processor
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         master_reset_pulse <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_block <= 48'h000000000000;
         cmd_legal <= 1'b0;
         cmd_diag <= 1'b0;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         // Processor firmware decides whether to self-test on this pulse
         master_reset_pulse <= wr_reset;
         cmd_valid <= state_ff == disk_port_pkg::D_CMD && req_ff && wr_data
                      && cnt_ff == disk_port_pkg::CMD_LEN - 3'h1 && !wr_reset;
         if (state_ff == disk_port_pkg::D_CMD && cnt_ff == disk_port_pkg::CMD_LEN - 3'h1) begin
            cmd_block <= {blk_ff[39:0], bus.bus_d};
            cmd_legal <= disk_port_pkg::op_legal(blk_ff[39:32]);
            cmd_diag <= blk_ff[39:37] == disk_port_pkg::DIAG_CLASS;
         end
         rx_valid <= state_ff == disk_port_pkg::D_DATA && !io_ff && req_ff && wr_data && !done;
         if (wr_data) begin
            rx_data <= bus.bus_d;
         end
      end
   end

   // Request mask; unused upper bits are dropped
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_ff <= disk_port_pkg::MASK_RST;
      end else if (wr_reset) begin
         mask_ff <= disk_port_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_ff <= bus.bus_d[1:0];
      end
   end

   // Read answers, one cycle after the strobe; port 323 stays undriven
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus.d_dout <= 8'h00;
         bus.d_oe_n <= 1'b1;
      end else begin
         bus.d_oe_n <= !(rd_data | rd_stat | rd_cfg | rom_hit);
         if (rd_data) begin
            bus.d_dout <= hold_ff;
         end else if (rd_stat) begin
            bus.d_dout <= status_byte;
         end else if (rd_cfg) begin
            bus.d_dout <= {4'h0, cfg_jumpers};
         end else if (rom_hit) begin
            bus.d_dout <= disk_port_pkg::rom_byte(bus.addr[disk_port_pkg::ROM_AW-1:0]);
         end
      end
   end

   // Request pins gated by the mask; lag the status bits by one cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus.dma_request_flag <= 1'b0;
         bus.irq <= 1'b0;
      end else begin
         bus.dma_request_flag <= dma_rdy & mask_ff[disk_port_pkg::MASK_DMA_REQUEST_ENABLE] & !wr_reset;
         bus.irq <= irq_pend_ff & mask_ff[disk_port_pkg::MASK_INTERRUPT_REQUEST_ENABLE] & !wr_reset;
      end
   end
endmodule

// ---- hdl/disk_port_pkg.sv ----
// Shared constants, encodings and state types for the disk host port
package disk_port_pkg;
   // Host I/O port addresses
   localparam logic [19:0] PORT_DATA = 20'h00320;
   localparam logic [19:0] PORT_STAT = 20'h00321;
   localparam logic [19:0] PORT_CFG = 20'h00322;
   localparam logic [19:0] PORT_MASK = 20'h00323;
   // Boot ROM window, arbitrary placement, 16 bytes
   localparam logic [19:0] ROM_BASE = 20'hE0000;
   localparam int ROM_AW = 4;
   localparam logic [7:0] ROM_SEED = 8'hA5;
   // Value seen on the data lines when nobody drives them
   localparam logic [7:0] BUS_IDLE = 8'hFF;
   // Hardware status bit positions
   localparam int ST_IRQ = 5;
   localparam int ST_DRQ = 4;
   localparam int ST_BSY = 3;
   localparam int ST_CD = 2;
   localparam int ST_IO = 1;
   localparam int ST_REQ = 0;
   // Request mask bit positions and reset value
   localparam int MASK_INTERRUPT_REQUEST_ENABLE = 1;
   localparam int MASK_DMA_REQUEST_ENABLE = 0;
   localparam logic [1:0] MASK_RST = 2'h0;
   // Command block length in bytes
   localparam logic [2:0] CMD_LEN = 3'h6;
   localparam logic [2:0] DIAG_CLASS = 3'h7;
   // Operational opcodes
   localparam logic [7:0] OP_TEST_READY = 8'h00;
   localparam logic [7:0] OP_RECAL = 8'h01;
   localparam logic [7:0] OP_LAST_STATUS = 8'h03;
   localparam logic [7:0] OP_FMT_DRIVE = 8'h04;
   localparam logic [7:0] OP_VERIFY = 8'h05;
   localparam logic [7:0] OP_FMT_TRACK = 8'h06;
   localparam logic [7:0] OP_FMT_BAD = 8'h07;
   localparam logic [7:0] OP_READ = 8'h08;
   localparam logic [7:0] OP_WRITE = 8'h0A;
   localparam logic [7:0] OP_SEEK = 8'h0B;
   localparam logic [7:0] OP_INIT_PARAM = 8'h0C;
   localparam logic [7:0] OP_BURST_LEN = 8'h0D;
   localparam logic [7:0] OP_READ_BUF = 8'h0E;
   localparam logic [7:0] OP_WRITE_BUF = 8'h0F;
   // Diagnostic opcodes
   localparam logic [7:0] OP_DIAG_BUF = 8'hE0;
   localparam logic [7:0] OP_DIAG_DRIVE = 8'hE3;
   localparam logic [7:0] OP_DIAG_CTRL = 8'hE4;
   localparam logic [7:0] OP_READ_LONG = 8'hE5;
   localparam logic [7:0] OP_WRITE_LONG = 8'hE6;
   // Host end register offsets and fields
   localparam logic [2:0] HREG_OP = 3'h0;
   localparam logic [2:0] HREG_WDATA = 3'h1;
   localparam logic [2:0] HREG_RESULT = 3'h2;
   localparam logic [2:0] HREG_STATUS = 3'h3;
   localparam logic [2:0] HREG_ROMADDR = 3'h4;
   localparam int OPF_READ = 2;
   localparam int OPF_MEM = 3;
   localparam int OPF_DMA = 4;
   localparam int HS_BUSY = 0;
   localparam int HS_IRQ = 1;
   localparam int HS_DRQ = 2;

   typedef enum logic [2:0] {
      D_NOT_READY = 3'b000,
      D_IDLE = 3'b001,
      D_CMD = 3'b010,
      D_EXEC = 3'b011,
      D_DATA = 3'b100,
      D_STAT = 3'b101
   } dev_state_e;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_DRQ = 2'b01,
      H_STROBE = 2'b10,
      H_CAPT = 2'b11
   } host_state_e;

   // Nineteen accepted opcodes
   function automatic logic op_legal(input logic [7:0] op);
      case (op)
         OP_TEST_READY, OP_RECAL, OP_LAST_STATUS, OP_FMT_DRIVE, OP_VERIFY,
         OP_FMT_TRACK, OP_FMT_BAD, OP_READ, OP_WRITE, OP_SEEK, OP_INIT_PARAM,
         OP_BURST_LEN, OP_READ_BUF, OP_WRITE_BUF, OP_DIAG_BUF, OP_DIAG_DRIVE,
         OP_DIAG_CTRL, OP_READ_LONG, OP_WRITE_LONG: op_legal = 1'b1;
         default: op_legal = 1'b0;
      endcase
   endfunction

   // Boot ROM contents, a fixed pattern
   function automatic logic [7:0] rom_byte(input logic [ROM_AW-1:0] idx);
      rom_byte = ROM_SEED ^ {4'h0, idx};
   endfunction
endpackage

// ---- hdl/disk_bus_if.sv ----
// Host bus between host end and controller port
`timescale 1ns/10ps
interface disk_bus_if;
   logic [19:0] addr;
   logic ior;
   logic iow;
   logic memr;
   logic dack;
   logic [7:0] h_dout;
   logic h_oe_n;
   logic [7:0] d_dout;
   logic d_oe_n;
   logic dma_request_flag;
   logic irq;
   logic [7:0] bus_d;

   // Resolved data lines, pulled high when idle
   assign bus_d = !h_oe_n ? h_dout : (!d_oe_n ? d_dout : disk_port_pkg::BUS_IDLE);

   modport dev (input addr, input ior, input iow, input memr, input dack, input bus_d,
                output d_dout, output d_oe_n, output dma_request_flag, output irq);
   modport host (output addr, output ior, output iow, output memr, output dack,
                 output h_dout, output h_oe_n, input bus_d, input dma_request_flag, input irq);
endinterface

// ---- hdl/disk_port_host.sv ----
// Host end: runs processor and DMA cycles on the port bus for software
`timescale 1ns/10ps
module disk_port_host (
   input wire logic clock,
   input wire logic rst,
   disk_bus_if.host bus,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   disk_port_pkg::host_state_e state_ff;
   logic [4:0] op_ff;
   logic [7:0] wdata_ff;
   logic [7:0] result_ff;
   logic [7:0] romaddr_ff;
   logic op_wr;
   logic launch;
   logic [4:0] op_now;
   logic [7:0] status_byte;

   assign op_wr = reg_wr && reg_addr == disk_port_pkg::HREG_OP;
   assign op_now = (state_ff == disk_port_pkg::H_IDLE) ? reg_wdata[4:0] : op_ff;
   // DMA waits for the request line; everything else starts at once
   assign launch = (state_ff == disk_port_pkg::H_IDLE && op_wr && !reg_wdata[disk_port_pkg::OPF_DMA])
                   || (state_ff == disk_port_pkg::H_DRQ && bus.dma_request_flag);

   // Host status view of the port lines
   always_comb begin
      status_byte = 8'h00;
      status_byte[disk_port_pkg::HS_BUSY] = state_ff != disk_port_pkg::H_IDLE;
      status_byte[disk_port_pkg::HS_IRQ] = bus.irq;
      status_byte[disk_port_pkg::HS_DRQ] = bus.dma_request_flag;
   end

   // Operation sequencer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= disk_port_pkg::H_IDLE;
         op_ff <= 5'h00;
         result_ff <= 8'h00;
      end else begin
         unique case (state_ff)
            disk_port_pkg::H_IDLE: begin
               if (op_wr) begin
                  op_ff <= reg_wdata[4:0];
                  state_ff <= launch ? disk_port_pkg::H_STROBE : disk_port_pkg::H_DRQ;
               end
            end
            disk_port_pkg::H_DRQ: begin
               if (op_wr && !reg_wdata[disk_port_pkg::OPF_DMA]) begin
                  state_ff <= disk_port_pkg::H_IDLE; // Cancel a stuck DMA wait
               end else if (launch) begin
                  state_ff <= disk_port_pkg::H_STROBE;
               end
            end
            disk_port_pkg::H_STROBE: begin
               state_ff <= disk_port_pkg::H_CAPT;
            end
            disk_port_pkg::H_CAPT: begin
               if (op_ff[disk_port_pkg::OPF_READ] || op_ff[disk_port_pkg::OPF_MEM]) begin
                  result_ff <= bus.bus_d;
               end
               state_ff <= disk_port_pkg::H_IDLE;
            end
         endcase
      end
   end

   // Bus strobes, one cycle wide; address held between cycles
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus.addr <= disk_port_pkg::PORT_DATA;
         bus.ior <= 1'b0;
         bus.iow <= 1'b0;
         bus.memr <= 1'b0;
         bus.dack <= 1'b0;
         bus.h_dout <= 8'h00;
         bus.h_oe_n <= 1'b1;
      end else begin
         bus.ior <= 1'b0;
         bus.iow <= 1'b0;
         bus.memr <= 1'b0;
         bus.dack <= 1'b0;
         bus.h_oe_n <= 1'b1;
         if (launch) begin
            if (op_now[disk_port_pkg::OPF_MEM]) begin
               bus.addr <= {disk_port_pkg::ROM_BASE[19:disk_port_pkg::ROM_AW],
                            romaddr_ff[disk_port_pkg::ROM_AW-1:0]};
               bus.memr <= 1'b1;
            end else begin
               bus.addr <= {disk_port_pkg::PORT_DATA[19:2], op_now[1:0]};
               bus.ior <= op_now[disk_port_pkg::OPF_READ];
               bus.iow <= !op_now[disk_port_pkg::OPF_READ];
               bus.dack <= op_now[disk_port_pkg::OPF_DMA];
               bus.h_oe_n <= op_now[disk_port_pkg::OPF_READ];
            end
            // Software writes zero into unused fields; sent byte as given
            bus.h_dout <= wdata_ff;
         end
      end
   end

   // Software registers; E4 is issued by software to force self-test
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wdata_ff <= 8'h00;
         romaddr_ff <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == disk_port_pkg::HREG_WDATA) begin
            wdata_ff <= reg_wdata;
         end
         if (reg_addr == disk_port_pkg::HREG_ROMADDR) begin
            romaddr_ff <= reg_wdata;
         end
      end
   end

   // Read data valid the cycle after the read strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            disk_port_pkg::HREG_OP: reg_rdata <= {3'h0, op_ff};
            disk_port_pkg::HREG_WDATA: reg_rdata <= wdata_ff;
            disk_port_pkg::HREG_RESULT: reg_rdata <= result_ff;
            disk_port_pkg::HREG_STATUS: reg_rdata <= status_byte;
            disk_port_pkg::HREG_ROMADDR: reg_rdata <= romaddr_ff;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// ---- tb/disk_port_chk.sv ----
// Assertions on the host port bus between both ends
`timescale 1ns/10ps
module disk_port_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic [19:0] addr,
   input wire logic ior,
   input wire logic iow,
   input wire logic memr,
   input wire logic dack,
   input wire logic d_oe_n,
   input wire logic dma_request_flag,
   input wire logic irq,
   input wire logic [7:0] bus_d
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Port cycles as the device sees them
   sequence st_rd; ior && !dack && addr == disk_port_pkg::PORT_STAT; endsequence
   sequence rom_rd; memr && addr[19:4] == disk_port_pkg::ROM_BASE[19:4]; endsequence
   sequence dma_cyc; dack && (ior || iow); endsequence
   a_status_driven: assert property (st_rd |=> !d_oe_n)
      else $error("status read not answered");
   a_status_unused: assert property (st_rd |=> bus_d[7:6] == 2'h0)
      else $error("unused status bits set");
   a_drq_in_data: assert property (st_rd ##1 bus_d[4] |-> bus_d[2] && bus_d[3])
      else $error("dma ready outside data phase");
   a_mask_no_read: assert property (ior && !dack && addr == disk_port_pkg::PORT_MASK |=> d_oe_n)
      else $error("mask port answered a read");
   a_reset_quiet: assert property (iow && !dack && addr == disk_port_pkg::PORT_STAT |=> (!dma_request_flag && !irq) [*2])
      else $error("requests left after master reset");
   a_rom_driven: assert property (rom_rd |=> !d_oe_n)
      else $error("rom read not answered");
   a_rom_data: assert property (rom_rd |=> bus_d == (disk_port_pkg::ROM_SEED ^ {4'h0, $past(addr[3:0])}))
      else $error("rom byte wrong");
   a_dma_drq_drop: assert property (dma_cyc |-> ##2 !dma_request_flag)
      else $error("dma request held after acknowledge");
   a_one_strobe: assert property ($onehot0({ior, iow, memr}))
      else $error("two strobes at once");
endmodule

// ---- tb/disk_controller_host_port_tb.sv ----
// Bench joining controller end and host end of the disk port
`timescale 1ns/10ps
module disk_controller_host_port_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic prdy = 1'b1, dstart = 1'b0, to_host = 1'b0, txv = 1'b0, done = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
   logic [3:0] jmp = 4'h0;
   logic [7:0] txd = 8'h00, dst = 8'h00, wd = 8'h00, rdata, rxd;
   logic [2:0] ra = 3'h0;
   logic mrp, cv, legal, diag, rxv, txr;
   logic [47:0] blk, blk_e;
   logic [15:0] e;
   logic [15:0] rq[$];
   logic [49:0] cq[$];
   logic [7:0] xq[$];
   logic [31:0] seed = 32'h17A2C;
   logic [7:0] ops[20] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B,
      8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'hE0, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'h02};
   int err_count = 0, n_tests = 0, ncmd = 0, nmr = 0, i, k;
   disk_bus_if bus();
   disk_port_dev disk_port_dev_i (.clock(clock), .rst(rst), .bus(bus.dev), .cfg_jumpers(jmp), .proc_ready(prdy),
      .data_start(dstart), .data_to_host(to_host), .tx_valid(txv), .tx_data(txd), .done(done),
      .done_status(dst), .master_reset_pulse(mrp), .cmd_valid(cv), .cmd_block(blk), .cmd_legal(legal),
      .cmd_diag(diag), .rx_valid(rxv), .rx_data(rxd), .tx_ready(txr));
   disk_port_host disk_port_host_i (.clock(clock), .rst(rst), .bus(bus.host), .reg_addr(ra),
      .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
   disk_port_chk disk_port_chk_i (.clock(clock), .rst(rst), .addr(bus.addr), .ior(bus.ior), .iow(bus.iow),
      .memr(bus.memr), .dack(bus.dack), .d_oe_n(bus.d_oe_n), .dma_request_flag(bus.dma_request_flag), .irq(bus.irq), .bus_d(bus.bus_d));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction
   task automatic chk(input string nm, input logic [49:0] got, input logic [49:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic test_done;
      $display("mismatches %0d, checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One strobe cycle on the register port, one idle edge after
   task automatic cyc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      ra <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Port cycle through the host end; a zero mask skips the result read
   task automatic io(input logic [7:0] op, input logic [7:0] d, input logic [7:0] m, input logic [7:0] x);
      cyc(1'b1, disk_port_pkg::HREG_WDATA, d);
      cyc(1'b1, disk_port_pkg::HREG_OP, op);
      repeat (8) @(posedge clock);
      if (m != 8'h00) begin
         rq.push_back({m, x});
         cyc(1'b0, disk_port_pkg::HREG_RESULT, 8'h00);
      end
   endtask
   // Processor side pulse: command end or data phase start
   task automatic dev(input logic fin, input logic h, input logic [7:0] s);
      @(posedge clock);
      done <= fin;
      dstart <= !fin;
      to_host <= h;
      dst <= s;
      @(posedge clock);
      done <= 1'b0;
      dstart <= 1'b0;
   endtask
   initial begin
      forever #2.5 clock = ~clock;
   end
   // Hang guard, far beyond the expected run
   initial begin
      #300000;
      err_count++;
      test_done();
   end
   // Oldest note against each answer as it appears
   always @(posedge clock) begin
      rd_d <= rd;
      if (rd_d) begin
         e = rq.pop_front();
         chk("result", {42'h0, rdata & e[15:8]}, {42'h0, e[7:0]});
      end
      if (cv) begin
         ncmd++;
         chk("command", {legal, diag, blk}, cq.pop_front());
      end
      if (rxv) chk("received", {42'h0, rxd}, {42'h0, xq.pop_front()});
      if (mrp) nmr++;
   end
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      seed = xs(seed);
      jmp <= seed[3:0];
      io(8'h05, 8'h00, 8'hFF, 8'h00);
      io(8'h06, 8'h00, 8'h0F, {4'h0, jmp});
      io(8'h07, 8'h00, 8'hFF, disk_port_pkg::BUS_IDLE);
      cyc(1'b1, disk_port_pkg::HREG_ROMADDR, {4'h0, seed[7:4]});
      io(8'h08, 8'h00, 8'hFF, disk_port_pkg::ROM_SEED ^ {4'h0, seed[7:4]});
      // Selection must raise busy and the handshake request
      io(8'h02, seed[15:8], 8'h00, 8'h00);
      io(8'h05, 8'h00, 8'hFF, 8'h09);
      // Processor held unready: a select after reset must be ignored
      prdy <= 1'b0;
      io(8'h01, seed[23:16], 8'h00, 8'h00);
      io(8'h02, seed[15:8], 8'h00, 8'h00);
      io(8'h05, 8'h00, 8'hFF, 8'h00);
      prdy <= 1'b1;
      io(8'h05, 8'h00, 8'hFF, 8'h00);
      io(8'h03, 8'h03, 8'h00, 8'h00);
      // Every opcode, then one outside the set
      for (i = 0; i < 20; i++) begin
         io(8'h02, seed[7:0], 8'h00, 8'h00);
         io(8'h05, 8'h00, 8'hFF, 8'h09);
         blk_e = {ops[i], 40'h0};
         for (k = 1; k < 6; k++) begin
            seed = xs(seed);
            blk_e[8*(5-k) +: 8] = seed[7:0];
         end
         cq.push_back({i < 19, ops[i][7:5] == 3'h7, blk_e});
         for (k = 0; k < 6; k++) io(8'h00, blk_e[8*(5-k) +: 8], 8'h00, 8'h00);
         for (k = 0; k < 20 && ncmd == i; k++) @(posedge clock);
         chk("commands", ncmd, i + 1);
         if (ops[i] == 8'h08) begin
            dev(1'b0, 1'b1, 8'h00);
            io(8'h05, 8'h00, 8'hFF, 8'h0E);
            @(posedge clock);
            txd <= seed[15:8];
            txv <= 1'b1;
            k = 0;
            do begin
               @(posedge clock);
               k++;
            end while (!txr && k < 20);
            txv <= 1'b0;
            io(8'h05, 8'h00, 8'hFF, 8'h1F);
            io(8'h14, 8'h00, 8'hFF, seed[15:8]);
         end
         if (ops[i] == 8'h0A) begin
            dev(1'b0, 1'b0, 8'h00);
            io(8'h05, 8'h00, 8'hFF, 8'h1D);
            xq.push_back(seed[23:16]);
            io(8'h10, seed[23:16], 8'h00, 8'h00);
         end
         dev(1'b1, 1'b0, seed[31:24]);
         io(8'h05, 8'h00, 8'hFF, 8'h2B);
         rq.push_back(16'h0602);
         cyc(1'b0, disk_port_pkg::HREG_STATUS, 8'h00);
         io(8'h04, 8'h00, 8'hFF, seed[31:24]);
         io(8'h05, 8'h00, 8'hFF, 8'h00);
      end
      // Last result read lands two edges later; let the watcher see it
      repeat (2) @(posedge clock);
      chk("resets", nmr, 1);
      chk("leftover notes", rq.size() + cq.size() + xq.size(), 0);
      test_done();
   end
endmodule
